//--- design/frmo_fifo_ctrl.sv
// fifo reset, timing mode, byte order and flag offset control
`timescale 1ns/1ns
`default_nettype none
module frmo_fifo_ctrl #(
	parameter int DEPTH_LOG2 = frmo_pkg::DEPTH_LOG2_DEF
) (
	// clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// asynchronous clear and configuration pins
	input wire logic i_full_clear_n,
	input wire logic i_partial_clear_n,
	input wire logic i_order_timing_select,
	input wire logic i_flag_select_0,
	input wire logic i_flag_select_1,
	input wire logic i_serial_program_mode_n,
	input wire logic i_serial_offset_in,
	input wire logic i_serial_offset_strobe_n,
	input wire logic i_retransmit_n,
	input wire logic [1:0] i_read_width,
	// write port
	input wire logic i_wr_en,
	input wire logic [frmo_pkg::LONG_W-1:0] i_wr_data,
	// read port
	input wire logic i_rd_en,
	output logic [frmo_pkg::LONG_W-1:0] o_rd_data,
	// flags
	output logic o_space_flag,
	output logic o_data_flag,
	output logic o_near_empty_flag,
	output logic o_near_full_flag,
	// latched configuration and offsets
	output logic o_fall_through_mode,
	output logic o_big_endian,
	output logic [DEPTH_LOG2-1:0] o_near_empty_offset,
	output logic [DEPTH_LOG2-1:0] o_near_full_offset
);
	localparam int LW = frmo_pkg::LONG_W;
	localparam int CW = DEPTH_LOG2 + 1;
	localparam int DEPTH = 1 << DEPTH_LOG2;
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam int LCW = $clog2(2 * DEPTH_LOG2 + 1);
	localparam logic [LCW-1:0] SER_LAST = LCW'(2 * DEPTH_LOG2 - 1);
	localparam logic [LCW-1:0] PAR_LAST = LCW'(1);

	logic [frmo_pkg::SYNC_W-1:0] pins;
	logic mr_s, pr_s, ots_s, fs0_s, fs1_s, spm_s, ser_s, stb_n_s, rt_s;
	logic [1:0] width_s;
	logic mr_prev, rt_prev, mr_rise, rt_go, clr;
	frmo_pkg::frmo_state_t state, next_state;
	frmo_pkg::frmo_ofs_mode_t load_method;
	logic [1:0] settle_cnt;
	logic mode_pending, offsets_pending;
	logic [LCW-1:0] load_cnt;
	logic load_wr, load_shift, load_done;
	logic [LW-1:0] mem [0:DEPTH-1];
	logic [CW-1:0] wptr, rptr, count;
	logic mem_has, full, wr_ok, wr_store;
	logic [LW-1:0] cur_word, rd_word;
	logic [2:0] part_idx, parts_left, nparts_m1;
	logic out_valid, avail, rd_fire, pop, advance, drain;
	logic [3:0] near_hold;

	// picks one read-port portion of a long word in the latched order
	function automatic logic [LW-1:0] portion(input logic [LW-1:0] w, input logic [1:0] code,
			input logic [2:0] k, input logic big);
		int size;
		int slot;
		logic [LW-1:0] mask;
		size = LW;
		slot = 0;
		portion = w; // long width: order does not apply
		case (code)
			frmo_pkg::WIDTH_WORD: size = frmo_pkg::PART_WORD;
			frmo_pkg::WIDTH_SHORT: size = frmo_pkg::PART_SHORT;
			frmo_pkg::WIDTH_BYTE: size = frmo_pkg::PART_BYTE;
			default: size = LW;
		endcase
		if (code != frmo_pkg::WIDTH_LONG) begin
			slot = big ? (LW / size) - 1 - int'(k) : int'(k);
			mask = ~({LW{1'b1}} << size);
			portion = (w >> (slot * size)) & mask;
		end
	endfunction

	// all pin inputs pass two flops first
	frmo_sync #(
		.W(frmo_pkg::SYNC_W),
		.RESET_VAL(frmo_pkg::SYNC_RESET)
	) u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_async({i_read_width, i_retransmit_n, i_serial_offset_strobe_n, i_serial_offset_in,
			i_serial_program_mode_n, i_flag_select_1, i_flag_select_0,
			i_order_timing_select, i_partial_clear_n, i_full_clear_n}),
		.o_sync(pins)
	);

	// unpack synchronised pins and derive clear, edges and counts
	assign mr_s = pins[frmo_pkg::SB_FULL_CLR];
	assign pr_s = pins[frmo_pkg::SB_PART_CLR];
	assign ots_s = pins[frmo_pkg::SB_ORDER_TIMING];
	assign fs0_s = pins[frmo_pkg::SB_FS0];
	assign fs1_s = pins[frmo_pkg::SB_FS1];
	assign spm_s = pins[frmo_pkg::SB_SPM_N];
	assign ser_s = pins[frmo_pkg::SB_SER_IN];
	assign stb_n_s = pins[frmo_pkg::SB_SER_STB_N];
	assign rt_s = pins[frmo_pkg::SB_RETX_N];
	assign width_s = pins[frmo_pkg::SB_WIDTH_LO +: 2];
	assign clr = !mr_s || !pr_s;
	assign mr_rise = mr_s && !mr_prev;
	assign rt_go = !rt_s && rt_prev && state == frmo_pkg::FRMO_RUN;
	assign count = wptr - rptr;
	assign mem_has = count != '0;
	assign full = count == FULL_CNT;
	assign rd_word = mem[rptr[DEPTH_LOG2-1:0]];

	// edge detect history of the synchronised clear and retransmit levels
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			mr_prev <= 1'b0;
			rt_prev <= 1'b1;
		end else if (i_ce) begin
			mr_prev <= mr_s;
			rt_prev <= rt_s;
		end
	end

	// next state of the clear / settle / load / run sequence
	always_comb begin
		next_state = state;
		case (state)
			frmo_pkg::FRMO_CLEAR: next_state = frmo_pkg::FRMO_SETTLE;
			frmo_pkg::FRMO_SETTLE: begin
				if (settle_cnt == 2'(frmo_pkg::SPACE_DELAY_CYC - 1)) begin
					next_state = offsets_pending ? frmo_pkg::FRMO_LOAD : frmo_pkg::FRMO_RUN;
				end
			end
			frmo_pkg::FRMO_LOAD: begin
				if (load_done) begin
					next_state = frmo_pkg::FRMO_RUN;
				end
			end
			frmo_pkg::FRMO_RUN: next_state = frmo_pkg::FRMO_RUN;
			default: next_state = frmo_pkg::FRMO_CLEAR;
		endcase
		if (clr) begin
			next_state = frmo_pkg::FRMO_CLEAR;
		end
	end

	// state register and settle counter
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state <= frmo_pkg::FRMO_CLEAR;
			settle_cnt <= 2'h0;
		end else if (i_ce) begin
			state <= next_state;
			settle_cnt <= (state == frmo_pkg::FRMO_SETTLE) ? settle_cnt + 2'h1 : 2'h0;
		end
	end

	// configuration latched at the full clear rising edge and after it
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_big_endian <= 1'b0;
			o_fall_through_mode <= 1'b0;
			load_method <= frmo_pkg::FRMO_OFS_PRESET;
			mode_pending <= 1'b0;
		end else if (i_ce) begin
			if (mr_rise) begin // only a full clear release changes the configuration
				o_big_endian <= ots_s;
				mode_pending <= 1'b1;
				if (!spm_s) begin
					load_method <= frmo_pkg::FRMO_OFS_SERIAL;
				end else if (fs0_s || fs1_s) begin
					load_method <= frmo_pkg::FRMO_OFS_PRESET;
				end else begin
					load_method <= frmo_pkg::FRMO_OFS_PARALLEL;
				end
			end else if (state == frmo_pkg::FRMO_SETTLE && settle_cnt == frmo_pkg::MODE_SAMPLE_CNT
					&& mode_pending) begin
				o_fall_through_mode <= !ots_s;
				mode_pending <= 1'b0;
			end
		end
	end

	// offset loading: preset, two parallel writes, or serial shifting
	assign load_wr = state == frmo_pkg::FRMO_LOAD && load_method == frmo_pkg::FRMO_OFS_PARALLEL
		&& wr_ok;
	assign load_shift = state == frmo_pkg::FRMO_LOAD && load_method == frmo_pkg::FRMO_OFS_SERIAL
		&& !stb_n_s;
	assign load_done = (load_wr && load_cnt == PAR_LAST) || (load_shift && load_cnt == SER_LAST);

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_near_empty_offset <= DEPTH_LOG2'(frmo_pkg::OFS_RESET);
			o_near_full_offset <= DEPTH_LOG2'(frmo_pkg::OFS_RESET);
			offsets_pending <= 1'b0;
			load_cnt <= '0;
		end else if (i_ce) begin
			if (mr_rise) begin
				offsets_pending <= !spm_s || !(fs0_s || fs1_s);
				load_cnt <= '0;
				if (spm_s && (fs0_s || fs1_s)) begin
					case ({fs1_s, fs0_s})
						2'h3: o_near_full_offset <= DEPTH_LOG2'(frmo_pkg::PRESET_64);
						2'h2: o_near_full_offset <= DEPTH_LOG2'(frmo_pkg::PRESET_16);
						default: o_near_full_offset <= DEPTH_LOG2'(frmo_pkg::PRESET_8);
					endcase
					case ({fs1_s, fs0_s})
						2'h3: o_near_empty_offset <= DEPTH_LOG2'(frmo_pkg::PRESET_64);
						2'h2: o_near_empty_offset <= DEPTH_LOG2'(frmo_pkg::PRESET_16);
						default: o_near_empty_offset <= DEPTH_LOG2'(frmo_pkg::PRESET_8);
					endcase
				end
			end else if (load_wr) begin
				if (load_cnt == '0) begin
					o_near_full_offset <= i_wr_data[DEPTH_LOG2-1:0];
				end else begin
					o_near_empty_offset <= i_wr_data[DEPTH_LOG2-1:0];
				end
				load_cnt <= load_cnt + LCW'(1);
				offsets_pending <= !load_done;
			end else if (load_shift) begin
				{o_near_full_offset, o_near_empty_offset} <= {o_near_full_offset[DEPTH_LOG2-2:0],
					o_near_empty_offset, ser_s};
				load_cnt <= load_cnt + LCW'(1);
				offsets_pending <= !load_done;
			end
		end
	end

	// write side: only a raised space flag lets a write in
	assign wr_ok = i_wr_en && o_space_flag && !full;
	assign wr_store = wr_ok && state == frmo_pkg::FRMO_RUN;

	always_ff @(posedge i_clk) begin
		if (i_ce && wr_store) begin
			mem[wptr[DEPTH_LOG2-1:0]] <= i_wr_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			wptr <= '0;
		end else if (i_ce) begin
			if (clr) begin
				wptr <= '0;
			end else if (wr_store) begin
				wptr <= wptr + CW'(1);
			end
		end
	end

	// read side decisions for classic and fall-through timing
	always_comb begin
		case (width_s)
			frmo_pkg::WIDTH_WORD: nparts_m1 = 3'h1;
			frmo_pkg::WIDTH_SHORT: nparts_m1 = 3'h3;
			frmo_pkg::WIDTH_BYTE: nparts_m1 = 3'h7;
			default: nparts_m1 = 3'h0;
		endcase
		avail = o_fall_through_mode ? out_valid : (mem_has || parts_left != 3'h0);
		rd_fire = i_rd_en && o_data_flag && avail && state == frmo_pkg::FRMO_RUN;
		advance = rd_fire && parts_left != 3'h0;
		pop = rd_fire && parts_left == 3'h0 && mem_has;
		drain = rd_fire && parts_left == 3'h0 && !mem_has;
		if (o_fall_through_mode && !out_valid && mem_has && state == frmo_pkg::FRMO_RUN) begin
			pop = 1'b1;
		end
	end

	// read pointer, output staging and portion stepping
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rptr <= '0;
			cur_word <= '0;
			part_idx <= 3'h0;
			parts_left <= 3'h0;
			out_valid <= 1'b0;
			o_rd_data <= '0;
		end else if (i_ce) begin
			if (clr || rt_go) begin
				rptr <= '0;
				parts_left <= 3'h0;
				out_valid <= 1'b0;
			end else if (pop) begin
				rptr <= rptr + CW'(1);
				cur_word <= rd_word;
				part_idx <= 3'h0;
				parts_left <= nparts_m1;
				out_valid <= 1'b1;
				o_rd_data <= portion(rd_word, width_s, 3'h0, o_big_endian);
			end else if (advance) begin
				part_idx <= part_idx + 3'h1;
				parts_left <= parts_left - 3'h1;
				o_rd_data <= portion(cur_word, width_s, part_idx + 3'h1, o_big_endian);
			end else if (drain) begin
				out_valid <= 1'b0;
			end
		end
	end

	// flags: forced by a clear, near flags held through retransmit recovery
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_space_flag <= 1'b0;
			o_data_flag <= 1'b0;
			o_near_empty_flag <= 1'b0;
			o_near_full_flag <= 1'b1;
			near_hold <= 4'h0;
		end else if (i_ce) begin
			if (clr) begin
				o_space_flag <= 1'b0;
				o_data_flag <= 1'b0;
				o_near_empty_flag <= 1'b0;
				o_near_full_flag <= 1'b1;
				near_hold <= 4'h0;
			end else begin
				o_space_flag <= (next_state == frmo_pkg::FRMO_RUN && !full)
					|| (next_state == frmo_pkg::FRMO_LOAD
					&& load_method == frmo_pkg::FRMO_OFS_PARALLEL);
				o_data_flag <= state == frmo_pkg::FRMO_RUN && !rt_go && avail;
				if (rt_go) begin
					near_hold <= frmo_pkg::NEAR_HOLD_CYC;
				end else if (near_hold != 4'h0) begin
					near_hold <= near_hold - 4'h1;
				end else begin
					o_near_empty_flag <= count > CW'(o_near_empty_offset);
					o_near_full_flag <= count < (FULL_CNT - CW'(o_near_full_offset));
				end
			end
		end
	end

	// checks on the clear, mode, offset and flag behaviour
	chk_clear_flags: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && clr |=> !o_space_flag && !o_data_flag && !o_near_empty_flag && o_near_full_flag
		&& wptr == '0 && rptr == '0)
		else $error("clear did not force pointers and flags");
	chk_space_delay: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && mr_rise && pr_s && spm_s && (fs0_s || fs1_s)) ##1 (i_ce && !clr)
		|-> !o_space_flag ##1 (i_ce && !clr) |=> o_space_flag)
		else $error("space flag not raised two cycles after clear");
	chk_order_latch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && mr_rise |=> o_big_endian == $past(ots_s))
		else $error("byte order not latched at clear release");
	chk_mode_sample: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && !clr && state == frmo_pkg::FRMO_SETTLE && settle_cnt == frmo_pkg::MODE_SAMPLE_CNT
		&& mode_pending |=> o_fall_through_mode == !$past(ots_s))
		else $error("timing mode not sampled on second edge");
	chk_partial_keep: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && mr_s && mr_prev && !pr_s |=> $stable(o_fall_through_mode)
		&& $stable(o_near_empty_offset) && $stable(o_near_full_offset) && $stable(load_method))
		else $error("partial clear changed configuration");
	chk_preset_64: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && mr_rise && spm_s && fs0_s && fs1_s |=> o_near_empty_offset == DEPTH_LOG2'(64)
		&& o_near_full_offset == DEPTH_LOG2'(64))
		else $error("preset 64 not loaded");
	chk_parallel_first: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && !clr && load_wr && load_cnt == '0 |=> o_near_full_offset ==
		$past(i_wr_data[DEPTH_LOG2-1:0]) && state == frmo_pkg::FRMO_LOAD && wptr == '0)
		else $error("first parallel write did not load near-full offset");
	chk_write_ignored: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && !clr && !o_space_flag |=> $stable(wptr))
		else $error("write accepted while space flag low");
	chk_fall_through: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && !clr && !rt_go && o_fall_through_mode && state == frmo_pkg::FRMO_RUN
		&& !out_valid && mem_has |=> out_valid && rptr == $past(rptr) + CW'(1))
		else $error("first word did not fall through");
	chk_big_first: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && !clr && !rt_go && pop && o_big_endian && width_s == frmo_pkg::WIDTH_BYTE
		|=> o_rd_data == {70'h0, $past(rd_word[79:70])})
		else $error("big endian did not deliver top byte first");
	chk_near_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && !clr && near_hold != 4'h0 |=> $stable(o_near_empty_flag)
		&& $stable(o_near_full_flag))
		else $error("near flags moved during retransmit recovery");
	chk_serial_space: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		state == frmo_pkg::FRMO_LOAD && load_method == frmo_pkg::FRMO_OFS_SERIAL |-> !o_space_flag)
		else $error("space flag high during serial loading");

	// main scenarios
	cov_parallel_done: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && load_wr && load_done);
	cov_serial_done: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && load_shift && load_done);
	cov_fall_through: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && o_fall_through_mode && pop && !rd_fire);
	cov_retransmit: cover property (@(posedge i_clk) disable iff (!i_rst_n) i_ce && rt_go);
endmodule // frmo_fifo_ctrl
`default_nettype wire

//--- design/frmo_pkg.sv
// constants and types shared by the fifo reset, mode and offset block
package frmo_pkg;
	// long-word width and the narrow portions of the read port
	localparam int LONG_W = 80;
	localparam int DEPTH_LOG2_DEF = 12;
	localparam int PART_WORD = 40;
	localparam int PART_SHORT = 20;
	localparam int PART_BYTE = 10;
	localparam logic [1:0] WIDTH_LONG = 2'h0;
	localparam logic [1:0] WIDTH_WORD = 2'h1;
	localparam logic [1:0] WIDTH_SHORT = 2'h2;
	localparam logic [1:0] WIDTH_BYTE = 2'h3;

	// positions of the pin inputs inside the synchroniser vector
	localparam int SYNC_W = 11;
	localparam int SB_FULL_CLR = 0;
	localparam int SB_PART_CLR = 1;
	localparam int SB_ORDER_TIMING = 2;
	localparam int SB_FS0 = 3;
	localparam int SB_FS1 = 4;
	localparam int SB_SPM_N = 5;
	localparam int SB_SER_IN = 6;
	localparam int SB_SER_STB_N = 7;
	localparam int SB_RETX_N = 8;
	localparam int SB_WIDTH_LO = 9;
	localparam logic [10:0] SYNC_RESET = 11'h000;

	// offset presets and the value held after reset
	localparam logic [6:0] PRESET_8 = 7'h08;
	localparam logic [6:0] PRESET_16 = 7'h10;
	localparam logic [6:0] PRESET_64 = 7'h40;
	localparam logic [6:0] OFS_RESET = 7'h40;

	// timing: clock, settle after a clear, retransmit recovery
	localparam int CLK_PERIOD_NS = 10;
	localparam int SPACE_DELAY_CYC = 2;
	localparam logic [1:0] MODE_SAMPLE_CNT = 2'h0;
	localparam int RTR_NS = 45;
	localparam int RTR_CYC = (RTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NEAR_EXTRA_CYC = 2;
	localparam logic [3:0] NEAR_HOLD_CYC = 4'(RTR_CYC + NEAR_EXTRA_CYC);

	typedef enum logic [1:0] {
		FRMO_CLEAR = 2'h0,
		FRMO_SETTLE = 2'h1,
		FRMO_LOAD = 2'h3,
		FRMO_RUN = 2'h2
	} frmo_state_t;

	typedef enum logic [1:0] {
		FRMO_OFS_PRESET = 2'h0,
		FRMO_OFS_PARALLEL = 2'h1,
		FRMO_OFS_SERIAL = 2'h3
	} frmo_ofs_mode_t;
endpackage

//--- design/frmo_sync.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none
module frmo_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	// clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// asynchronous levels in, synchronised levels out
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	// one pair of flops per bit; the first flop feeds only the second
	for (genvar b = 0; b < W; b++) begin : g_bit
		logic meta;
		always_ff @(posedge i_clk) begin
			if (!i_rst_n) begin
				meta <= RESET_VAL[b];
				o_sync[b] <= RESET_VAL[b];
			end else if (i_ce) begin
				meta <= i_async[b];
				o_sync[b] <= meta;
			end
		end
	end
endmodule // frmo_sync
`default_nettype wire

//--- sim/frmo_host_model.sv
// host-side model that drives the clear and configuration pins
`timescale 1ns/1ns
`default_nettype none
module frmo_host_model (
	// clock
	input wire logic i_clk,
	// clear and configuration pins
	output logic o_full_clear_n,
	output logic o_partial_clear_n,
	output logic o_order_timing_select,
	output logic o_flag_select_0,
	output logic o_flag_select_1,
	output logic o_serial_program_mode_n
);
	// full clear is asserted from power-up until the first release
	initial begin
		o_full_clear_n = 1'h0;
		o_partial_clear_n = 1'h1;
		o_order_timing_select = 1'h0;
		o_flag_select_0 = 1'h0;
		o_flag_select_1 = 1'h0;
		o_serial_program_mode_n = 1'h1;
	end

	// full clear: set the selects, hold low five edges, release; select then stays put
	task automatic full_clear(input logic sel, input logic fs1, input logic fs0,
			input logic spm_n);
		@(negedge i_clk);
		o_full_clear_n = 1'h0;
		o_order_timing_select = sel;
		o_flag_select_1 = fs1;
		o_flag_select_0 = fs0;
		o_serial_program_mode_n = spm_n;
		repeat (5) @(negedge i_clk);
		o_full_clear_n = 1'h1;
	endtask

	// partial clear: hold low five edges, then release
	task automatic partial_clear();
		@(negedge i_clk);
		o_partial_clear_n = 1'h0;
		repeat (5) @(negedge i_clk);
		o_partial_clear_n = 1'h1;
	endtask
endmodule // frmo_host_model
`default_nettype wire

//--- sim/frmo_fifo_ctrl_tb_top.sv
// testbench for the fifo reset, mode and offset control
`timescale 1ns/1ns
`default_nettype none
module frmo_fifo_ctrl_tb_top;
	logic clk;
	logic rst_n;
	logic wr_en;
	logic rd_en;
	logic [1:0] width;
	logic [79:0] wr_data;
	logic [79:0] rd_data;
	logic fc_n, pc_n, sel, fs0, fs1, spm_n;
	logic rt_n, sd, sen_n;
	logic space, dflag, ne, nf, ft, be;
	logic [11:0] ne_ofs;
	logic [11:0] nf_ofs;
	int failures = 0;
	int n_checks = 0;

	frmo_host_model host (.i_clk(clk), .o_full_clear_n(fc_n), .o_partial_clear_n(pc_n),
		.o_order_timing_select(sel), .o_flag_select_0(fs0), .o_flag_select_1(fs1),
		.o_serial_program_mode_n(spm_n));

	frmo_fifo_ctrl u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'h1), .i_full_clear_n(fc_n),
		.i_partial_clear_n(pc_n), .i_order_timing_select(sel), .i_flag_select_0(fs0),
		.i_flag_select_1(fs1), .i_serial_program_mode_n(spm_n), .i_serial_offset_in(sd),
		.i_serial_offset_strobe_n(sen_n), .i_retransmit_n(rt_n), .i_read_width(width),
		.i_wr_en(wr_en), .i_wr_data(wr_data), .i_rd_en(rd_en), .o_rd_data(rd_data),
		.o_space_flag(space), .o_data_flag(dflag), .o_near_empty_flag(ne),
		.o_near_full_flag(nf), .o_fall_through_mode(ft), .o_big_endian(be),
		.o_near_empty_offset(ne_ofs), .o_near_full_offset(nf_ofs));

	// free-running clock
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	// compare and count
	task automatic chk(input string name, input logic [79:0] seen, input logic [79:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// verdict and end of run
	task automatic give_verdict();
		if (failures == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// bounded wait for the data flag or the space flag
	task automatic wait_hi(input bit dat);
		int n;
		n = 0;
		while ((dat ? dflag : space) !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > 20) begin
				chk("flag wait", 80'h0, 80'h1);
				give_verdict();
			end
		end
	endtask

	// flags while a clear is still seen
	task automatic chk_cleared();
		chk("space flag", space, 1'h0);
		chk("data flag", dflag, 1'h0);
		chk("near empty", ne, 1'h0);
		chk("near full", nf, 1'h1);
	endtask

	// one write, then one read, each a single cycle
	task automatic wr(input logic [79:0] d);
		@(negedge clk);
		wr_en = 1'h1;
		wr_data = d;
		@(negedge clk);
		wr_en = 1'h0;
	endtask

	task automatic rd();
		@(negedge clk);
		rd_en = 1'h1;
		@(negedge clk);
		rd_en = 1'h0;
	endtask

	// main sequence
	initial begin
		logic [2:0] cfg [3] = '{3'h7, 3'h2, 3'h5};
		logic [6:0] pre [3] = '{frmo_pkg::PRESET_64, frmo_pkg::PRESET_16, frmo_pkg::PRESET_8};
		logic [79:0] word = 80'h8badc0ffee0123456789;
		logic [23:0] bits = 24'ha5c3c1;
		rst_n = 1'h0;
		rt_n = 1'h1;
		sd = 1'h0;
		sen_n = 1'h1;
		wr_en = 1'h0;
		rd_en = 1'h0;
		wr_data = 80'h0;
		width = frmo_pkg::WIDTH_BYTE;
		repeat (6) @(negedge clk);
		rst_n = 1'h1;
		// presets, byte order and timing mode for each select level
		for (int i = 0; i < 3; i++) begin
			host.full_clear(cfg[i][2], cfg[i][1], cfg[i][0], 1'h1);
			chk_cleared();
			wait_hi(0);
			chk("near empty ofs", ne_ofs, pre[i]);
			chk("near full ofs", nf_ofs, pre[i]);
			chk("big endian", be, cfg[i][2]);
			chk("fall through", ft, !cfg[i][2]);
			wr(word);
			wait_hi(1);
			if (cfg[i][2]) begin
				rd(); // classic needs a read even for the first word
			end
			chk("rd portion", rd_data, cfg[i][2] ? {70'h0, word[79:70]} : {70'h0, word[9:0]});
		end
		// parallel loading, with a write dropped while space is low
		width = frmo_pkg::WIDTH_LONG;
		host.full_clear(1'h1, 1'h0, 1'h0, 1'h1);
		wr_en = 1'h1;
		wr_data = 80'h5a5;
		@(negedge clk);
		wr_en = 1'h0;
		wait_hi(0);
		wr(80'hf0000000000000000fff);
		wr(80'h0ffffffffffffffff000);
		chk("near full ofs", nf_ofs, 12'hfff);
		chk("near empty ofs", ne_ofs, 12'h000);
		wait_hi(0);
		wr(word);
		wait_hi(1);
		rd();
		chk("rd long word", rd_data, word);
		// partial clear keeps offsets and modes
		host.partial_clear();
		chk_cleared();
		wait_hi(0);
		chk("near full ofs", nf_ofs, 12'hfff);
		chk("near empty ofs", ne_ofs, 12'h000);
		chk("fall through", ft, 1'h0);
		chk("big endian", be, 1'h1);
		// retransmit replays from the start; near flags wait out the recovery
		wr(word);
		wr(~word);
		wait_hi(1);
		rd();
		rd();
		chk("rd second word", rd_data, ~word);
		@(negedge clk);
		rt_n = 1'h0;
		@(negedge clk);
		rt_n = 1'h1;
		repeat (4) @(negedge clk);
		chk("near empty hold", ne, 1'h0);
		chk("near full hold", nf, 1'h1);
		repeat (10) @(negedge clk);
		chk("near empty after", ne, 1'h1);
		chk("near full after", nf, 1'h0);
		wait_hi(1);
		rd();
		chk("rd replay", rd_data, word);
		// serial loading: space stays low until all bits are shifted in
		host.full_clear(1'h1, 1'h0, 1'h0, 1'h0);
		repeat (8) @(negedge clk);
		chk("space serial", space, 1'h0);
		for (int b = 23; b >= 0; b--) begin
			sd = bits[b];
			sen_n = 1'h0;
			@(negedge clk);
		end
		sen_n = 1'h1;
		wait_hi(0);
		chk("near full ofs", nf_ofs, bits[23:12]);
		chk("near empty ofs", ne_ofs, bits[11:0]);
		give_verdict();
	end
endmodule // frmo_fifo_ctrl_tb_top
`default_nettype wire
